// [verilog/sep_top.sv]
// serial eeprom port: command decode, status word and write protection
// Operation
// - output changes only after serial clock falls
// - input sampled on serial clock rising edge
// - deselected means output high impedance
// - standby when deselected unless programming
// - no operation before first select falling edge
// - lock bit clear: status write needs latch
// - lock set, pin high: latch allows write
// - lock set, pin low: status writes ignored
// - protected array bytes read-only in hardware mode
// - hardware mode entered in either order
// - only raising protect pin leaves hardware mode
// - latch and busy bits still update internally
// - pin held high: only block protection
// - set-write-enable code sets the latch
// - latch cleared on reset, clear code and accepted writes
// - block bits choose quarter, half or all
// - msb first, first bit after select
`default_nettype none
module sep_top import sep_pkg::*; (
   // core clock and control
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        ce_in,
   // serial pins
   input  wire logic        sclk_in,
   input  wire logic        cs_n_in,
   input  wire logic        din_in,
   input  wire logic        wp_n_in,
   output logic             q_out,
   output logic             q_oe_out,
   // status and array write request
   output logic [7:0]       status_out,
   output logic             hw_protect_out,
   output logic             standby_out,
   output logic             busy_out,
   output logic             arr_wr_out,
   output logic [14:0]      arr_addr_out,
   output logic [7:0]       arr_data_out,
   output logic             wr_blocked_out
);
   sep_link_if lk ();

   // serial clock domain lives in its own module
   sep_link u_link (
      .sclk_in (sclk_in),
      .cs_n_in (cs_n_in),
      .din_in  (din_in),
      .lk      (lk)
   );

   // block protect decode, used for write gating and its check
   function automatic logic region_prot(input logic [1:0] bp, input logic [14:0] a);
      unique case (bp)
         2'h0: region_prot = 1'b0;
         2'h1: region_prot = (a >= QUARTER_BASE);
         2'h2: region_prot = (a >= HALF_BASE);
         2'h3: region_prot = 1'b1;
      endcase
   endfunction : region_prot

   // status word packing, used for the pins and the shifter snapshot
   function automatic logic [7:0] stat_pack(input logic lk_b, input logic [1:0] bp,
                                            input logic we, input logic bz);
      stat_pack                       = 8'h00;
      stat_pack[LOCK_POS]             = lk_b;
      stat_pack[BP_HI_POS:BP_LO_POS]  = bp;
      stat_pack[WEL_POS]              = we;
      stat_pack[BUSY_POS]             = bz;
   endfunction : stat_pack

   logic        cs_s1_r;
   logic        cs_s2_r;
   logic        cs_d_r;
   logic        wp_s1_r;
   logic        wp_s2_r;
   logic        tg_s1_r;
   logic        tg_s2_r;
   logic        tg_d_r;
   logic        link_rst_r;
   logic [1:0]  warm_r;
   logic        seen_hi_r;
   logic        armed_r;
   logic [2:0]  idx_r;
   logic [7:0]  op_r;
   logic [7:0]  sr_data_r;
   logic [14:0] addr_r;
   logic [7:0]  data_r;
   logic        lock_r;
   logic [1:0]  bp_r;
   logic        wel_r;
   sep_wstate_t st_r;
   logic [15:0] prog_cnt_r;
   logic [7:0]  snap_r;
   logic        hpm_out_r;
   logic        standby_r;
   logic        arr_wr_r;
   logic        blocked_r;

   // frame and byte events seen in the core domain
   wire logic cs_rise  = cs_s2_r & ~cs_d_r;
   wire logic cs_fall  = ~cs_s2_r & cs_d_r;
   wire logic byte_ev  = (tg_s2_r ^ tg_d_r) & ~cs_s2_r & armed_r;
   wire logic busy     = (st_r == ST_PROGRAM);
   wire logic first_b  = byte_ev & (idx_r == 3'h0);

   // protection decisions, taken when the request is made
   wire logic hardware_protected_mode       = lock_r & ~wp_s2_r;
   wire logic sr_ok     = wel_r & ~hardware_protected_mode & ~busy;
   wire logic wr_ok     = wel_r & ~busy & ~region_prot(bp_r, addr_r);
   wire logic set_wen   = first_b & (lk.rx_byte == OP_SET_WEN) & ~busy;
   wire logic clr_wen   = first_b & (lk.rx_byte == OP_CLR_WEN) & ~busy;
   wire logic exec_status_write_cmd = ce_in & cs_rise & armed_r & (op_r == OP_WR_STAT)
                          & (idx_r == IDX_SR_DONE);
   wire logic exec_wr   = ce_in & cs_rise & armed_r & (op_r == OP_WR_ARR)
                          & (idx_r == IDX_SAT);
   wire logic sr_go     = exec_status_write_cmd & sr_ok;
   wire logic wr_go     = exec_wr & wr_ok;
   wire logic [7:0] stat_now = stat_pack(lock_r, bp_r, wel_r, busy);

   // pin synchronisers, first stage read only by the second
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         cs_d_r  <= 1'b1;
         wp_s1_r <= 1'b1;
         wp_s2_r <= 1'b1;
      end else if (ce_in) begin
         cs_s1_r <= cs_n_in;
         cs_s2_r <= cs_s1_r;
         cs_d_r  <= cs_s2_r;
         wp_s1_r <= wp_n_in;
         wp_s2_r <= wp_s1_r;
      end
   end

   // byte toggle crossing from the shifter
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         tg_s1_r <= 1'b0;
         tg_s2_r <= 1'b0;
         tg_d_r  <= 1'b0;
      end else if (ce_in) begin
         tg_s1_r <= lk.rx_tgl;
         tg_s2_r <= tg_s1_r;
         tg_d_r  <= tg_s2_r;
      end
   end

   // shifter reset follows core reset, held a cycle past release
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         link_rst_r <= 1'b1;
      end else begin
         link_rst_r <= 1'b0;
      end
   end

   // select level trusted only once reset values have left the synchroniser;
   // otherwise a select held low through reset looks like a fresh fall
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         warm_r    <= 2'h0;
         seen_hi_r <= 1'b0;
      end else if (ce_in) begin
         warm_r <= {warm_r[0], 1'b1};
         if (warm_r[1] && cs_s2_r) begin
            seen_hi_r <= 1'b1;
         end
      end
   end

   // armed only by a high-to-low select after power-on
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         armed_r <= 1'b0;
      end else if (ce_in && cs_fall && seen_hi_r) begin
         armed_r <= 1'b1;
      end
   end

   // frame byte index and captured fields
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         idx_r <= 3'h0;
      end else if (ce_in && cs_s2_r) begin
         idx_r <= 3'h0;
      end else if (ce_in && byte_ev && idx_r != IDX_SAT) begin
         idx_r <= idx_r + 3'h1;
      end
   end

   // opcode, status byte, address and first data byte, msb first
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         op_r      <= 8'h00;
         sr_data_r <= 8'h00;
         addr_r    <= 15'h0000;
         data_r    <= 8'h00;
      end else if (ce_in && byte_ev) begin
         unique case (idx_r)
            3'h0: op_r <= lk.rx_byte;
            3'h1: begin
               sr_data_r    <= lk.rx_byte;
               addr_r[14:8] <= lk.rx_byte[6:0];
            end
            3'h2: addr_r[7:0] <= lk.rx_byte;
            3'h3: data_r <= lk.rx_byte;
            default: ;
         endcase
      end
   end

   // status lock and block bits, written only when protection allows
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         lock_r <= LOCK_RST;
         bp_r   <= BP_RST;
      end else if (sr_go) begin
         lock_r <= sr_data_r[LOCK_POS];
         bp_r   <= sr_data_r[BP_HI_POS:BP_LO_POS];
      end
   end

   // write enable latch keeps updating under pin protection
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         wel_r <= 1'b0;
      end else if (ce_in) begin
         if (set_wen) begin
            wel_r <= 1'b1;
         end else if (clr_wen || sr_go || wr_go) begin
            wel_r <= 1'b0;
         end
      end
   end

   // self-timed program cycle, a refused write starts nothing
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st_r       <= ST_READY;
         prog_cnt_r <= 16'h0000;
      end else if (ce_in) begin
         unique case (st_r)
            ST_READY: if (sr_go || wr_go) begin
               st_r       <= ST_PROGRAM;
               prog_cnt_r <= PROG_CYC - 16'h0001;
            end
            ST_PROGRAM: if (prog_cnt_r == 16'h0000) begin
               st_r <= ST_READY;
            end else begin
               prog_cnt_r <= prog_cnt_r - 16'h0001;
            end
         endcase
      end
   end

   // snapshot frozen while selected so the shifter sees a steady word
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         snap_r <= 8'h00;
      end else if (ce_in && cs_s2_r) begin
         snap_r <= stat_now;
      end
   end

   // registered outputs
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         hpm_out_r <= 1'b0;
         standby_r <= 1'b1;
         arr_wr_r  <= 1'b0;
         blocked_r <= 1'b0;
      end else if (ce_in) begin
         hpm_out_r <= hardware_protected_mode;
         standby_r <= cs_s2_r & ~busy;
         arr_wr_r  <= wr_go;
         blocked_r <= (exec_wr & ~wr_ok) | (exec_status_write_cmd & ~sr_ok);
      end
   end

   // status pins and array request data
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         status_out   <= 8'h00;
         busy_out     <= 1'b0;
         arr_addr_out <= 15'h0000;
         arr_data_out <= 8'h00;
      end else if (ce_in) begin
         status_out <= stat_now;
         busy_out   <= busy;
         if (wr_go) begin
            arr_addr_out <= addr_r;
            arr_data_out <= data_r;
         end
      end
   end

   assign lk.stat_snap  = snap_r;
   assign lk.link_rst   = link_rst_r;
   assign q_out         = lk.q;
   assign q_oe_out      = lk.q_oe;
   assign hw_protect_out = hpm_out_r;
   assign standby_out   = standby_r;
   assign arr_wr_out    = arr_wr_r;
   assign wr_blocked_out = blocked_r;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   // program running with the latch already cleared
   sequence s_wr_started;
      busy && !wel_r;
   endsequence

   AST_LATCH_NEEDS_ARM: assert property (
      $rose(wel_r) |-> $past(armed_r))
      else $error("latch set before the first select");
   AST_LOCKED_SR_IGNORED: assert property (
      (exec_status_write_cmd && hardware_protected_mode) |=> $stable(lock_r) && $stable(bp_r) && !$rose(busy))
      else $error("status changed in hardware protected mode");
   AST_SR_WRITE_TAKEN: assert property (
      sr_go |=> (lock_r == $past(sr_data_r[LOCK_POS])) and s_wr_started)
      else $error("allowed status write not taken");
   AST_HPM_FLAG: assert property (
      (ce_in && lock_r && !wp_s2_r) |=> hw_protect_out)
      else $error("hardware mode flag missing");
   AST_HPM_EXIT_BY_PIN: assert property (
      $fell(hw_protect_out) |-> $past(wp_s2_r))
      else $error("hardware mode left without the pin high");
   AST_SET_WEN: assert property (
      (ce_in && set_wen) |=> wel_r ##1 (wel_r || !cs_s2_r || busy || !ce_in))
      else $error("set write enable ignored");
   AST_ARRAY_PROTECT: assert property (
      arr_wr_out |-> !region_prot(bp_r, arr_addr_out) && busy)
      else $error("write issued into protected block");
   AST_STANDBY: assert property (
      standby_out |-> $past(cs_s2_r) && !$past(busy))
      else $error("standby during programming or selection");
   AST_PROG_LENGTH: assert property (
      wr_go |=> s_wr_started ##1 busy[*3])
      else $error("program cycle shorter than expected");
   AST_BLOCKED_QUIET: assert property (
      wr_blocked_out |-> $stable(lock_r) && !arr_wr_out)
      else $error("blocked request had side effects");
endmodule : sep_top
`default_nettype wire

// [pkg/sep_pkg.sv]
// constants and types shared by the serial eeprom port and its link shifter
`default_nettype none
package sep_pkg;
   // instruction codes, most significant bit first on the wire
   localparam logic [7:0] OP_SET_WEN  = 8'h06;
   localparam logic [7:0] OP_CLR_WEN  = 8'h04;
   localparam logic [7:0] OP_RD_STAT  = 8'h05;
   localparam logic [7:0] OP_WR_STAT  = 8'h01;
   localparam logic [7:0] OP_RD_ARR   = 8'h03;
   localparam logic [7:0] OP_WR_ARR   = 8'h02;
   // status word field positions
   localparam int         LOCK_POS    = 7;
   localparam int         BP_HI_POS   = 3;
   localparam int         BP_LO_POS   = 2;
   localparam int         WEL_POS     = 1;
   localparam int         BUSY_POS    = 0;
   // reset values of the status fields
   localparam logic       LOCK_RST    = 1'b0;
   localparam logic [1:0] BP_RST      = 2'h0;
   // protected region bases
   localparam int         ADDR_W      = 15;
   localparam logic [14:0] QUARTER_BASE = 15'h6000;
   localparam logic [14:0] HALF_BASE    = 15'h4000;
   // frame byte index, saturates once a data byte has arrived
   localparam logic [2:0] IDX_SR_DONE = 3'h2;
   localparam logic [2:0] IDX_SAT     = 3'h4;
   // self-timed program time, least time so round up
   localparam int          CLK_NS     = 4;
   localparam int          PROG_NS    = 1000;
   localparam logic [15:0] PROG_CYC   = 16'((PROG_NS + CLK_NS - 1) / CLK_NS);
   // program engine states
   typedef enum logic {
      ST_READY,
      ST_PROGRAM
   } sep_wstate_t;
endpackage : sep_pkg
`default_nettype wire

// [pkg/sep_link_if.sv]
// signals between the core and the serial-clock link shifter
`default_nettype none
interface sep_link_if;
   logic [7:0] rx_byte;
   logic       rx_tgl;
   logic [7:0] stat_snap;
   logic       link_rst;
   logic       q;
   logic       q_oe;
   modport link (
      output rx_byte, rx_tgl, q, q_oe,
      input  stat_snap, link_rst
   );
   modport core (
      input  rx_byte, rx_tgl, q, q_oe,
      output stat_snap, link_rst
   );
endinterface : sep_link_if
`default_nettype wire

// [verilog/sep_link.sv]
// serial clock domain shifter: receive on rising, transmit on falling edge
`default_nettype none
module sep_link import sep_pkg::*; (
   // serial pins
   input  wire logic sclk_in,
   input  wire logic cs_n_in,
   input  wire logic din_in,
   // core side
   sep_link_if.link  lk
);
   logic [2:0] bit_cnt_r;
   logic [6:0] rx_sh_r;
   logic       first_r;
   logic       rdsr_r;
   logic [6:0] tx_sh_r;
   logic       q_r;
   logic       oe_r;
   logic       tgl_r;
   logic [7:0] byte_r;

   // decode of the incoming bit stream
   wire logic [7:0] rx_full  = {rx_sh_r, din_in};
   wire logic       byte_end = (bit_cnt_r == 3'h7);

   // bit counter and shift, cleared by deselect
   always_ff @(posedge sclk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         bit_cnt_r <= 3'h0;
         rx_sh_r   <= 7'h00;
         first_r   <= 1'b0;
         rdsr_r    <= 1'b0;
      end else begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         rx_sh_r   <= rx_full[6:0];
         if (byte_end && !first_r) begin
            first_r <= 1'b1;
            rdsr_r  <= (rx_full == OP_RD_STAT);
         end
      end
   end

   // byte handoff; not cleared by deselect so the last byte survives it
   always_ff @(posedge sclk_in or posedge lk.link_rst) begin
      if (lk.link_rst) begin
         tgl_r  <= 1'b0;
         byte_r <= 8'h00;
      end else if (byte_end) begin
         byte_r <= rx_full;
         tgl_r  <= ~tgl_r;
      end
   end

   // status shifted out after falling edges, high impedance when deselected
   always_ff @(negedge sclk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         q_r     <= 1'b0;
         oe_r    <= 1'b0;
         tx_sh_r <= 7'h00;
      end else if (rdsr_r) begin
         oe_r <= 1'b1;
         if (bit_cnt_r == 3'h0) begin
            {q_r, tx_sh_r} <= lk.stat_snap;
         end else begin
            {q_r, tx_sh_r} <= {tx_sh_r, 1'b0};
         end
      end
   end

   assign lk.rx_byte = byte_r;
   assign lk.rx_tgl  = tgl_r;
   assign lk.q       = q_r;
   assign lk.q_oe    = oe_r;

   // output only drives during a status read
   AST_Q_ONLY_ON_READ: assert property (
      @(negedge sclk_in) disable iff (cs_n_in) oe_r |-> $past(rdsr_r))
      else $error("serial output enabled outside a status read");

   // first bit after the opcode is the top status bit
   AST_Q_MSB_FIRST: assert property (
      @(negedge sclk_in) disable iff (cs_n_in)
      (oe_r && bit_cnt_r == 3'h1) |-> q_r == lk.stat_snap[LOCK_POS])
      else $error("status not shifted msb first");
endmodule : sep_link
`default_nettype wire

// [tb/sep_spi_master.sv]
// serial bus master model driving the eeprom port in mode 0
`default_nettype none
module sep_spi_master (
   // serial pins towards the device
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      din_out,
   // device answer
   input  wire logic q_in,
   input  wire logic q_oe_in
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HALF = 16;
   // clock parked low outside frames, device deselected
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      din_out  = 1'b0;
   end
   // select level alone, only to break the arming order on purpose
   task automatic set_sel(input logic lvl);
      cs_n_out = lvl;
   endtask : set_sel
   // msb first out, answer taken at each rising edge
   task automatic shift(input int nbits, input logic [39:0] tx, output logic [39:0] rx);
      rx = '0;
      for (int i = nbits - 1; i >= 0; i--) begin
         din_out = tx[i];
         #(HALF) sclk_out = 1'b1;
         rx[i] = q_oe_in ? q_in : 1'bx; // a released output is never trusted
         #(HALF) sclk_out = 1'b0;
      end
      #(HALF) din_out = ~din_out; // no stale bit lingers once the bits are done
   endtask : shift
   // whole frame: select first, hold after the last edge, then a gap
   task automatic frame(input int nbits, input logic [39:0] tx, output logic [39:0] rx);
      cs_n_out = 1'b0;
      #(HALF);
      shift(nbits, tx, rx);
      #(8) cs_n_out = 1'b1;
      #(3 * HALF);
   endtask : frame
endmodule : sep_spi_master
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the serial eeprom port and its write protection
`default_nettype none
module tb;
   import sep_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   // clock, control, pins and bookkeeping
   logic        clk_in    = 1'b0;
   logic        reset_in  = 1'b1;
   logic        wp_n_in   = 1'b0;
   logic        sclk, cs_n, din, q_out, q_oe_out;
   logic [7:0]  status_out, arr_data_out;
   logic [14:0] arr_addr_out;
   logic        hw_protect_out, standby_out, busy_out, arr_wr_out, wr_blocked_out;
   logic        wr_seen, blk_seen;
   logic        q_bad     = 1'b0;
   int          error_cnt = 0;
   int          cmp_count = 0;
   logic [39:0] rx;
   localparam logic [14:0] ADDRS [4] = '{15'h3fff, 15'h4000, 15'h5fff, 15'h6000};

   always #2 clk_in = ~clk_in;

   sep_top DUT (.clk_in(clk_in), .reset_in(reset_in), .ce_in(1'b1), .sclk_in(sclk),
      .cs_n_in(cs_n), .din_in(din), .wp_n_in(wp_n_in), .q_out(q_out), .q_oe_out(q_oe_out),
      .status_out(status_out), .hw_protect_out(hw_protect_out), .standby_out(standby_out),
      .busy_out(busy_out), .arr_wr_out(arr_wr_out), .arr_addr_out(arr_addr_out),
      .arr_data_out(arr_data_out), .wr_blocked_out(wr_blocked_out));

   sep_spi_master m (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .q_in(q_out),
      .q_oe_in(q_oe_out));

   // one-cycle pulses are caught here so a task can judge them later
   always @(posedge clk_in) begin
      if (arr_wr_out === 1'b1) wr_seen <= 1'b1;
      if (wr_blocked_out === 1'b1) blk_seen <= 1'b1;
   end
   // output moving while the serial clock is high
   always @(q_out) if (sclk === 1'b1 && cs_n === 1'b0) q_bad = 1'b1;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic summarize();
      if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : cyc

   function automatic logic [4:0] fld(input logic [7:0] s);
      return {s[LOCK_POS], s[BP_HI_POS], s[BP_LO_POS], s[WEL_POS], s[BUSY_POS]};
   endfunction : fld

   // one frame of whole bytes, then time for the frame action to land
   task automatic cmd(input int nb, input logic [31:0] tx);
      wr_seen = 1'b0;
      blk_seen = 1'b0;
      m.frame(nb * 8, {8'h00, tx}, rx);
      cyc(8);
   endtask : cmd

   task automatic wait_idle();
      int n;
      n = 0;
      while (busy_out !== 1'b0 && n < 400) begin
         cyc(1);
         n++;
      end
      if (n >= 400) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, busy_out, 1'b0);
         summarize();
      end
   endtask : wait_idle

   task automatic rd_status(input logic [4:0] exp);
      m.frame(16, 40'h0500, rx);
      chk({rx[7], rx[3:0]}, exp);
      chk(q_bad, 1'b0);
      cyc(2);
      chk(q_oe_out, 1'b0);
   endtask : rd_status

   // select already low across reset, so the enable byte must be ignored
   task automatic t_arming();
      chk(status_out, 8'h00);
      cyc(4);
      m.shift(8, 40'h06, rx);
      m.set_sel(1'b1);
      cyc(12);
      chk(status_out[1], 1'b0);
      chk(standby_out, 1'b1);
      chk(q_oe_out, 1'b0);
   endtask : t_arming

   // lock clear with the pin low: latch alone decides
   task automatic t_soft_lock();
      cmd(1, 32'h06);
      chk(status_out[1], 1'b1);
      rd_status(5'b00010);
      cmd(2, 32'h018c);
      chk(fld(status_out), 5'b11101);
      chk(standby_out, 1'b0);
      rd_status(5'b11101);
      wait_idle();
      chk(fld(status_out), 5'b11100);
      chk(hw_protect_out, 1'b1);
   endtask : t_soft_lock

   task automatic t_hw_mode();
      cmd(1, 32'h06);
      chk(status_out[1], 1'b1);
      cmd(2, 32'h0100);
      chk(blk_seen, 1'b1);
      chk(fld(status_out), 5'b11110);
      chk(busy_out, 1'b0);
      cmd(4, 32'h0201235a);
      chk(blk_seen, 1'b1);
      chk(wr_seen, 1'b0);
      cmd(1, 32'h04);
      chk(status_out[1], 1'b0);
   endtask : t_hw_mode

   task automatic t_release();
      wp_n_in = 1'b1;
      cyc(6);
      chk(hw_protect_out, 1'b0);
      cmd(1, 32'h06);
      cmd(2, 32'h0184);
      wait_idle();
      chk(fld(status_out), 5'b10100);
      chk(hw_protect_out, 1'b0);
   endtask : t_release

   // every block code against addresses on both sides of each base
   task automatic t_regions();
      logic prot;
      for (int bp = 0; bp < 4; bp++) begin
         cmd(1, 32'h06);
         cmd(2, {16'h0001, 4'h0, 2'(bp), 2'h0});
         wait_idle();
         for (int k = 0; k < 4; k++) begin
            prot = bp == 3 || (bp == 2 && ADDRS[k] >= HALF_BASE)
                   || (bp == 1 && ADDRS[k] >= QUARTER_BASE);
            cmd(1, 32'h06);
            cmd(4, {8'h02, 1'b0, ADDRS[k], 8'h50 + 8'(k)});
            chk(wr_seen, !prot);
            chk(blk_seen, prot);
            if (!prot) begin
               chk(arr_addr_out, ADDRS[k]);
               chk(arr_data_out, 8'h50 + 8'(k));
               wait_idle();
               chk(status_out[1], 1'b0);
            end
         end
      end
   endtask : t_regions

   // pin dropped after the lock is set; unprotected bytes stay writable
   task automatic t_late_pin();
      cmd(1, 32'h06);
      cmd(2, 32'h0180);
      wait_idle();
      wp_n_in = 1'b0;
      cyc(6);
      chk(hw_protect_out, 1'b1);
      cmd(1, 32'h06);
      cmd(4, 32'h02000011);
      chk(wr_seen, 1'b1);
      wait_idle();
   endtask : t_late_pin

   // main sequence
   initial begin
      #1 m.set_sel(1'b0);
      repeat (2) @(posedge clk_in);
      #1 reset_in = 1'b0;
      t_arming();
      t_soft_lock();
      t_hw_mode();
      t_release();
      t_regions();
      t_late_pin();
      summarize();
   end
endmodule : tb
`default_nettype wire
